// ### rtl/tsd_consts.svh
`ifndef TSD_CONSTS_SVH
`define TSD_CONSTS_SVH

// interpolator/status field layout
`define TSD_STAT_W        16
`define TSD_INTERP_W      12
`define TSD_INHIBIT_BIT   12
`define TSD_SEL_A_BIT     13
`define TSD_SEL_B_BIT     14
`define TSD_BLKSTART_BIT  15

// register byte offsets
`define TSD_CTRL_OFS      12'h000
`define TSD_STATUS_OFS    12'h004
`define TSD_COUNT_OFS     12'h008
`define TSD_ADDR_W        12

// control bit positions
`define TSD_CTRL_EN       0
`define TSD_CTRL_MODE     1
`define TSD_CTRL_CHAN     2
`define TSD_CTRL_EXP      3

// reset values
`define TSD_CTRL_RST      4'h0
`define TSD_COUNT_RST     16'h0000

`endif

// ### rtl/tsd_pkg.sv
`default_nettype none
package tsd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FIRST  = 3'b010,
    ST_SECOND = 3'b100
  } rec_state_e;

  typedef enum logic {
    ARM_SAMPLING      = 1'b0,
    ARM_TIME_INTERVAL = 1'b1
  } arm_mode_e;
endpackage
`default_nettype wire

// ### rtl/tsd_apb_regs.sv
`include "tsd_consts.svh"
`default_nettype none
module tsd_apb_regs
  import tsd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        enable,
  output arm_mode_e                   arm_mode,
  output logic                        channel_b,
  output logic                        expanded,
  input  wire logic                   busy,
  input  wire logic [2:0]             state_code,
  input  wire logic [15:0]            sample_count
);
  logic [3:0] ctrl;
  logic       setup;
  logic       mapped;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a[`TSD_ADDR_W-1:0] == `TSD_CTRL_OFS) ||
                (a[`TSD_ADDR_W-1:0] == `TSD_STATUS_OFS) ||
                (a[`TSD_ADDR_W-1:0] == `TSD_COUNT_OFS);
  endfunction

  assign setup  = psel && !penable;
  assign mapped = is_mapped(paddr) && (paddr[31:`TSD_ADDR_W] == '0);
  assign pready = 1'b1;  // zero wait states

  // read data and error captured in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (!pwrite && mapped) begin
        unique case (paddr[`TSD_ADDR_W-1:0])
          `TSD_CTRL_OFS:   prdata <= {28'h000_0000, ctrl};
          `TSD_STATUS_OFS: prdata <= {28'h000_0000, state_code, busy};
          default:         prdata <= {16'h0000, sample_count};
        endcase
      end
    end
  end

  // control register write at the access edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= `TSD_CTRL_RST;
    end else if (psel && penable && pwrite &&
                 paddr[`TSD_ADDR_W-1:0] == `TSD_CTRL_OFS && paddr[31:`TSD_ADDR_W] == '0) begin
      ctrl <= pwdata[3:0];
    end
  end

  assign enable    = ctrl[`TSD_CTRL_EN];
  assign arm_mode  = arm_mode_e'(ctrl[`TSD_CTRL_MODE]);
  assign channel_b = ctrl[`TSD_CTRL_CHAN];
  assign expanded  = ctrl[`TSD_CTRL_EXP];
endmodule
`default_nettype wire

// ### rtl/totalize_sample_stream_decoder.sv
// Behaviour
// R1: each sample is captured twice; both attempts go out as separate records
// R2: first record carries first count and status-only field: block start, inhibit
// R3: second record carries second count, time count and interpolator data
// R4: sampling-armed modes put the selector in bit 13 of the status field
// R5: time/interval-armed mode puts the selector in bit 14 of the status field
// R6: sampling-armed layout holds for either channel, expanded data on or off
// R7: consumer takes first count unchanged when selector reads 0
// R8: consumer takes second count minus one when selector reads 1
// R9: consumer adds event overflow correction from any decreasing count onward
// R10: consumer adds time overflow correction from any decreasing time onward
// R11: consumer corrects time rollover before folding in interpolator data
// R12: time stamp equals time count times 2 ns minus interpolator times 0.1 ns
// R13: totalize result is next valid event stamp minus current one
// R14: with expanded data, gate time is next time stamp minus current one
// R15: consumer keeps both overflow corrections as configurable parameters
//
// Register access over APB and the register addresses were decided locally.
`include "tsd_consts.svh"
`default_nettype none
module totalize_sample_stream_decoder
  import tsd_pkg::*;
#(
  parameter int EVENT_W = 32,
  parameter int TIME_W  = 32
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // capture side
  input  wire logic                     sample_valid,
  output logic                          sample_ready,
  input  wire logic [EVENT_W-1:0]       first_count,
  input  wire logic [EVENT_W-1:0]       second_count,
  input  wire logic [TIME_W-1:0]        time_count,
  input  wire logic [`TSD_INTERP_W-1:0] interp,
  input  wire logic                     block_start,
  input  wire logic                     inhibit,
  input  wire logic                     count_select,
  // record stream
  output logic                          rec_valid,
  input  wire logic                     rec_ready,
  output logic                          rec_second,
  output logic [EVENT_W-1:0]            rec_event,
  output logic [TIME_W-1:0]             rec_time,
  output logic [`TSD_STAT_W-1:0]        rec_status
);
  rec_state_e                   state;
  arm_mode_e                    arm_mode;
  arm_mode_e                    held_mode;
  logic                         enable;
  logic                         channel_b;
  logic                         expanded;
  logic                         accept;
  logic                         handed;
  logic [EVENT_W-1:0]           held_second;
  logic [TIME_W-1:0]            held_time;
  logic [`TSD_INTERP_W-1:0]     held_interp;
  logic                         held_sel;
  logic [15:0]                  sample_count;

  generate
    if (EVENT_W < 2 || EVENT_W > 32 || TIME_W < 2 || TIME_W > 32) begin : g_bad
      $error("counter widths must lie between 2 and 32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status field builders
  function automatic logic [`TSD_STAT_W-1:0] first_status(input logic bs, input logic inh);
    first_status                    = '0;
    first_status[`TSD_BLKSTART_BIT] = bs;   // see R2
    first_status[`TSD_INHIBIT_BIT]  = inh;  // see R2
  endfunction

  function automatic logic [`TSD_STAT_W-1:0] second_status(input arm_mode_e m,
                                                           input logic sel,
                                                           input logic [`TSD_INTERP_W-1:0] ip);
    second_status                      = '0;
    second_status[`TSD_INTERP_W-1:0]   = ip;  // see R3
    if (m == ARM_SAMPLING) begin
      second_status[`TSD_SEL_A_BIT] = sel;  // see R4
    end else begin
      second_status[`TSD_SEL_B_BIT] = sel;  // see R5
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file
  tsd_apb_regs u_regs (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .enable       (enable),
    .arm_mode     (arm_mode),
    .channel_b    (channel_b),
    .expanded     (expanded),
    .busy         (state != ST_IDLE),
    .state_code   (state),
    .sample_count (sample_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing: one sample in, two records out
  assign sample_ready = enable && (state == ST_IDLE);
  assign accept       = sample_valid && sample_ready;
  assign handed       = rec_valid && rec_ready;
  assign rec_valid    = (state == ST_FIRST) || (state == ST_SECOND);
  assign rec_second   = (state == ST_SECOND);

  // record state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:   if (accept) state <= ST_FIRST;   // see R1
        ST_FIRST:  if (handed) state <= ST_SECOND;  // see R1
        ST_SECOND: if (handed) state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // second-attempt data held while the first record waits;
  // channel and expanded setting do not alter the layout (see R6)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held_second <= '0;
      held_time   <= '0;
      held_interp <= '0;
      held_sel    <= 1'b0;
      held_mode   <= ARM_SAMPLING;
    end else if (accept) begin
      held_second <= second_count;
      held_time   <= time_count;
      held_interp <= interp;
      held_sel    <= count_select;
      held_mode   <= arm_mode;  // mode frozen per sample
    end
  end

  // record data registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rec_event  <= '0;
      rec_time   <= '0;
      rec_status <= '0;
    end else if (accept) begin
      rec_event  <= first_count;                        // see R2
      rec_time   <= '0;                                 // unused in first record
      rec_status <= first_status(block_start, inhibit); // see R2
    end else if (state == ST_FIRST && handed) begin
      rec_event  <= held_second;                        // see R3
      rec_time   <= held_time;                          // see R3
      rec_status <= second_status(held_mode, held_sel, held_interp);
    end
  end

  // completed samples
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_count <= `TSD_COUNT_RST;
    end else if (state == ST_SECOND && handed) begin
      sample_count <= sample_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  first_after_accept_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    accept |=> rec_valid && !rec_second && rec_event == $past(first_count))
    else $error("first record missing after sample");

  second_follows_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    (handed && !rec_second) |=> rec_valid && rec_second)
    else $error("second record did not follow first");

  record_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    (rec_valid && !rec_ready) |=> rec_valid && $stable(rec_event) && $stable(rec_time)
                                  && $stable(rec_status) && $stable(rec_second))
    else $error("record changed while stalled");

  first_status_only_a: assert property (@(posedge clk) disable iff (sys_rst) // see R2
    (rec_valid && !rec_second) |-> rec_time == '0 &&
      (rec_status & ~first_status(1'b1, 1'b1)) == '0)
    else $error("first record carries more than status");

  second_fields_a: assert property (@(posedge clk) disable iff (sys_rst) // see R3
    (rec_valid && rec_second) |-> rec_event == held_second && rec_time == held_time
      && rec_status[`TSD_INTERP_W-1:0] == held_interp)
    else $error("second record fields wrong");

  sel_bit13_a: assert property (@(posedge clk) disable iff (sys_rst) // see R4
    (rec_valid && rec_second && held_mode == ARM_SAMPLING) |->
      rec_status[`TSD_SEL_A_BIT] == held_sel && !rec_status[`TSD_SEL_B_BIT])
    else $error("sampling selector misplaced");

  sel_bit14_a: assert property (@(posedge clk) disable iff (sys_rst) // see R5
    (rec_valid && rec_second && held_mode == ARM_TIME_INTERVAL) |->
      rec_status[`TSD_SEL_B_BIT] == held_sel && !rec_status[`TSD_SEL_A_BIT])
    else $error("time/interval selector misplaced");

  layout_chan_a: assert property (@(posedge clk) disable iff (sys_rst) // see R6
    (accept && arm_mode == ARM_SAMPLING && (channel_b || expanded)) ##1 handed |=>
      rec_status[`TSD_SEL_A_BIT] == held_sel)
    else $error("layout changed with channel or expanded setting");

  pair_done_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    (handed && rec_second) |=> !rec_valid)
    else $error("extra record after the pair");

  second_capture_a: assert property (@(posedge clk) disable iff (sys_rst) // see R3
    accept |=> held_second == $past(second_count) && held_time == $past(time_count)
      && held_interp == $past(interp))
    else $error("second-attempt data not captured with the sample");
endmodule
`default_nettype wire

// ### testbench/rec_sink.sv
`include "tsd_consts.svh"
`default_nettype none
module rec_sink #(
  parameter logic [63:0] EVENT_OVF = 64'h0000_0001_0000_0000,
  parameter logic [63:0] TIME_OVF  = 64'h0000_0001_0000_0000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        expanded,
  input  wire logic        rec_valid,
  input  wire logic        rec_second,
  input  wire logic [31:0] rec_event,
  input  wire logic [31:0] rec_time,
  input  wire logic [15:0] rec_status,
  output logic             rec_ready,
  output logic [31:0]      valid_event,
  output logic [63:0]      total,
  output logic [63:0]      gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        have_prev;
  logic [31:0] first_seen, merged_event, prev_event, prev_time;
  logic [63:0] event_ofs, time_ofs, next_event_ofs, next_time_ofs;
  logic [63:0] event_stamp, time_stamp, prev_event_stamp, prev_time_stamp;
  //////////////////////////////////////////////////////////////////////
  // accept at once, or stall on a coin toss when told to be slow
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rec_ready <= 1'b0;
    end else begin
      rec_ready <= slow ? 1'($urandom) : 1'b1;
    end
  end
  // merge the two attempts into one valid count, then fold rollovers in;
  // time stamps count tenths of a nanosecond
  always_comb begin
    merged_event   = (rec_status[`TSD_SEL_A_BIT] | rec_status[`TSD_SEL_B_BIT]) ?
                     rec_event - 32'h0000_0001 : first_seen;
    next_event_ofs = (have_prev && merged_event < prev_event) ?
                     event_ofs + EVENT_OVF : event_ofs;
    next_time_ofs  = (have_prev && rec_time < prev_time) ?
                     time_ofs + TIME_OVF : time_ofs;
    event_stamp    = 64'(merged_event) + next_event_ofs;
    // rollover corrected first, interpolator subtracted after
    time_stamp     = (64'(rec_time) + next_time_ofs) * 64'h0000_0000_0000_0014
                     - 64'(rec_status[`TSD_INTERP_W-1:0]);
  end
  // first count at the first handshake, per-sample state and results at the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_seen       <= 32'h0000_0000;
      valid_event      <= 32'h0000_0000;
      have_prev        <= 1'b0;
      prev_event       <= 32'h0000_0000;
      prev_time        <= 32'h0000_0000;
      event_ofs        <= 64'h0000_0000_0000_0000;
      time_ofs         <= 64'h0000_0000_0000_0000;
      prev_event_stamp <= 64'h0000_0000_0000_0000;
      prev_time_stamp  <= 64'h0000_0000_0000_0000;
      total            <= 64'h0000_0000_0000_0000;
      gate             <= 64'h0000_0000_0000_0000;
    end else if (rec_valid && rec_ready && !rec_second) begin
      first_seen <= rec_event;
    end else if (rec_valid && rec_ready) begin
      valid_event      <= merged_event;
      have_prev        <= 1'b1;
      prev_event       <= merged_event;
      prev_time        <= rec_time;
      event_ofs        <= next_event_ofs;
      time_ofs         <= next_time_ofs;
      prev_event_stamp <= event_stamp;
      prev_time_stamp  <= time_stamp;
      if (have_prev) begin
        total <= event_stamp - prev_event_stamp;
      end
      if (have_prev && expanded) begin
        gate <= time_stamp - prev_time_stamp;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`include "tsd_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, slow;
  logic        sample_valid, sample_ready, block_start, inhibit, count_select;
  logic        rec_valid, rec_ready, rec_second, e_sel, e_bs, e_inh;
  logic [31:0] paddr, pwdata, prdata, rd, rec_event, rec_time, valid_event;
  logic [31:0] first_count, second_count, time_count, e_first, e_second, e_time;
  logic [11:0] interp, e_ip;
  logic [15:0] rec_status;
  logic [3:0]  ctrl;
  int          miscompares, check_count;
  logic        have;
  logic [31:0] ev, p_ev, p_tm;
  logic [63:0] total, gate, es, ts, p_es, p_ts, ev_ofs, tm_ofs, tot_exp, g_exp;
  localparam logic [63:0] EV_OVF = 64'h0000_0001_0000_0000;
  localparam logic [63:0] TM_OVF = 64'h0000_0001_0000_0000;
  totalize_sample_stream_decoder i_totalize_sample_stream_decoder (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .first_count(first_count),
    .second_count(second_count), .time_count(time_count), .interp(interp),
    .block_start(block_start), .inhibit(inhibit), .count_select(count_select),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_second(rec_second),
    .rec_event(rec_event), .rec_time(rec_time), .rec_status(rec_status));
  rec_sink #(.EVENT_OVF(EV_OVF), .TIME_OVF(TM_OVF)) i_rec_sink (
    .clk(clk), .sys_rst(sys_rst), .slow(slow), .expanded(ctrl[3]), .rec_valid(rec_valid),
    .rec_second(rec_second), .rec_event(rec_event), .rec_time(rec_time),
    .rec_status(rec_status), .rec_ready(rec_ready), .valid_event(valid_event),
    .total(total), .gate(gate));
  //////////////////////////////////////////////////////////////////////
  // compare and report
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected second-record status, bits 12 and 15 masked out
  function logic [15:0] exp_stat(input logic m, input logic s, input logic [11:0] ip);
    return {1'b0, m & s, ~m & s, 1'b0, ip};
  endfunction
  // time stamp in tenths of a nanosecond from a corrected time count
  function automatic logic [63:0] stamp(input logic [31:0] t, input logic [63:0] ofs,
                                         input logic [11:0] ip);
    return (64'(t) + ofs) * 64'h0000_0000_0000_0014 - 64'(ip);
  endfunction
  // offer one sample, then check both records at their handshakes
  task send;
    @(posedge clk);
    slow <= 1'($urandom);
    sample_valid <= 1'b1;
    first_count <= e_first;
    second_count <= e_second;
    time_count <= e_time;
    interp <= e_ip;
    {count_select, block_start, inhibit} <= {e_sel, e_bs, e_inh};
    do @(negedge clk); while (sample_ready !== 1'b1);
    @(posedge clk);
    sample_valid <= 1'b0;
    first_count <= ~e_first;
    second_count <= ~e_second;
    time_count <= ~e_time;
    interp <= ~e_ip;
    count_select <= ~e_sel;
    do @(negedge clk); while (!(rec_valid === 1'b1 && rec_ready === 1'b1));
    chk(32'(rec_second), 32'h0000_0000);
    chk(rec_event, e_first);
    chk(rec_time, 32'h0000_0000);
    chk(32'(rec_status), 32'({e_bs, 2'b00, e_inh, 12'h000}));
    @(posedge clk);
    do @(negedge clk); while (!(rec_valid === 1'b1 && rec_ready === 1'b1));
    chk(32'(rec_second), 32'h0000_0001);
    chk(rec_event, e_second);
    chk(rec_time, e_time);
    chk(32'(rec_status & 16'h6fff), 32'(exp_stat(ctrl[1], e_sel, e_ip)));
    @(posedge clk);
    @(negedge clk);
    chk(valid_event, e_sel ? e_second - 32'h0000_0001 : e_first);
    // consumer results worked out from the stimulus alone
    ev = e_sel ? e_second - 32'h0000_0001 : e_first;
    ev_ofs = (have && ev < p_ev) ? ev_ofs + EV_OVF : ev_ofs;
    tm_ofs = (have && e_time < p_tm) ? tm_ofs + TM_OVF : tm_ofs;
    es = 64'(ev) + ev_ofs;
    ts = stamp(e_time, tm_ofs, e_ip);
    if (have) begin
      tot_exp = es - p_es;
      g_exp = ctrl[3] ? ts - p_ts : g_exp;
    end
    chk(total, tot_exp);
    chk(gate, g_exp);
    {have, p_ev, p_tm, p_es, p_ts} = {1'b1, ev, e_time, es, ts};
  endtask
  //////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sample_valid, slow} = '0;
    {first_count, second_count, time_count, interp} = '0;
    {block_start, inhibit, count_select, ctrl} = '0;
    {have, ev_ofs, tm_ofs, tot_exp, g_exp} = '0;
    sys_rst = 1'b1;
    void'($urandom(70829));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, 32'(`TSD_CTRL_OFS), 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 32'(`TSD_STATUS_OFS), 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 32'h0000_000c, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    apb(1'b1, 32'(`TSD_COUNT_OFS), 32'h0000_ffff);
    apb(1'b0, 32'(`TSD_COUNT_OFS), 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // disabled block must refuse samples
    sample_valid <= 1'b1;
    repeat (4) @(negedge clk);
    chk(32'(sample_ready), 32'h0000_0000);
    @(posedge clk);
    sample_valid <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (i % 4 == 0) begin
        ctrl = 4'($urandom);
        ctrl[0] = 1'b1;
        ctrl[1] = i[2];
        apb(1'b1, 32'(`TSD_CTRL_OFS), {28'hfff_ffff, ctrl});
        apb(1'b0, 32'(`TSD_CTRL_OFS), 32'h0000_0000);
        chk(rd, {28'h000_0000, ctrl});
      end
      e_first = (i == 1) ? 32'hffff_ffff : $urandom;
      e_second = (i == 1) ? 32'h0000_0000 : $urandom;
      e_time = (i == 1) ? 32'h0000_0000 : $urandom;
      e_ip = 12'($urandom);
      {e_sel, e_bs, e_inh} = 3'($urandom);
      send;
    end
    apb(1'b0, 32'(`TSD_COUNT_OFS), 32'h0000_0000);
    chk(rd, 32'h0000_0018);
    stop_test;
  end
endmodule
`default_nettype wire
